// ==== hdl/sdc_pkg.sv ====
// Purpose: Shared constants for the sensor drive current configuration block
// Assumes: Word-wide register port with 8-bit register index
// Notes:   Field positions and offsets are fixed by the register map
package sdc_pkg;
  // Register indices
  localparam logic [7:0] SDC_OFS_SETUP = 8'h1A;
  localparam logic [7:0] SDC_OFS_LVL0  = 8'h1E;
  localparam logic [7:0] SDC_OFS_LVL1  = 8'h1F;
  localparam logic [7:0] SDC_OFS_LVL2  = 8'h20;
  localparam logic [7:0] SDC_OFS_LVL3  = 8'h21;
  // Setup register fields
  localparam int SDC_BIT_OVERRIDE = 12;
  localparam int SDC_BIT_ACTSEL   = 11;
  localparam int SDC_BIT_AMPOFF   = 10;
  localparam int SDC_BIT_BOOST    = 6;
  // Level register fields
  localparam int SDC_PROG_HI = 15;
  localparam int SDC_PROG_LO = 11;
  localparam int SDC_CAL_HI  = 10;
  localparam int SDC_CAL_LO  = 6;
  // Reset values and maximum code
  localparam logic [15:0] SDC_SETUP_RST = 16'h0000;
  localparam logic [4:0]  SDC_CODE_RST  = 5'h00;
  localparam logic [4:0]  SDC_CODE_MAX  = 5'h1F;
  // Writable bits of the setup register
  localparam logic [15:0] SDC_SETUP_MASK = 16'h1C40;
  // Drive phase of a channel
  typedef enum logic [1:0] {
    SDC_PH_OFF    = 2'b00,
    SDC_PH_SETTLE = 2'b01,
    SDC_PH_CONV   = 2'b10
  } sdc_phase_t;
endpackage

// ==== hdl/sdc_code_reg.sv ====
// Purpose: One channel's programmed and calibrated drive codes
// Assumes: Host writes and calibration captures are single-cycle strobes
// Notes:   Applied code is latched only at the start of settling
`timescale 1ns/100ps
module sdc_code_reg
  import sdc_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // Host write
  input  wire logic       progWe,
  input  wire logic [4:0] progIn,
  // Calibration capture
  input  wire logic       calWe,
  input  wire logic [4:0] calIn,
  // Phase start
  input  wire logic       settleStart,
  // Stored values
  output logic [4:0]      progCode,
  output logic [4:0]      calCode,
  output logic [4:0]      appliedCode
);
  logic [4:0] prog_q, prog_d;  // Programmed code
  logic [4:0] cal_q, cal_d;    // Calibrated code
  logic [4:0] app_q, app_d;    // Code held for the current dwell

  // Next-state for the three fields
  always_comb begin
    prog_d = prog_q;
    cal_d  = cal_q;
    app_d  = app_q;
    if (progWe) begin
      prog_d = progIn;
    end
    if (calWe) begin
      cal_d = calIn;
    end
    if (settleStart) begin
      app_d = progWe ? progIn : prog_q;
    end
  end

  // Registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prog_q <= SDC_CODE_RST;
      cal_q  <= SDC_CODE_RST;
      app_q  <= SDC_CODE_RST;
    end else begin
      prog_q <= prog_d;
      cal_q  <= cal_d;
      app_q  <= app_d;
    end
  end

  assign progCode    = prog_q;
  assign calCode     = cal_q;
  assign appliedCode = app_q;

  code_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !settleStart |=> app_q == $past(app_q))
    else $error("applied code changed outside settling start");
endmodule

// ==== hdl/sdc_amp_mon.sv ====
// Purpose: Amplitude window classification for one active channel
// Assumes: Analog comparators give synchronous level flags
// Notes:   Flags are registered so status reads are glitch free
`timescale 1ns/100ps
module sdc_amp_mon (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  // Comparator levels
  input  wire logic ampBelowLow,   // Below 1.2 V peak
  input  wire logic ampAboveHigh,  // Above 1.8 V peak
  input  wire logic ampBelowStop,  // Below 0.6 V peak
  input  wire logic active,
  // Registered flags
  output logic      ampOutWindow,
  output logic      oscStopped
);
  logic win_q, win_d;
  logic stop_q, stop_d;

  always_comb begin
    win_d  = active & (ampBelowLow | ampAboveHigh);
    stop_d = active & ampBelowStop;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      win_q  <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      win_q  <= win_d;
      stop_q <= stop_d;
    end
  end

  assign ampOutWindow = win_q;
  assign oscStopped   = stop_q;

  stop_flag_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (active && ampBelowStop) |=> oscStopped)
    else $error("oscillation stop not flagged");
endmodule

// ==== hdl/sdc_drive_cfg.sv ====
// Purpose: Sensor drive current configuration registers and drive selection
// Assumes: Register port is word wide, index addressed, single-cycle strobes
// Notes:   Sequencer supplies active channel and phase; calibrator its codes
`timescale 1ns/100ps

// Contract
// - Apply programmed code during settle and conversion
// - Programmed code needs override and correction off
// - Store calibrated code, never drive with it
// - Setup bit 12 enables fixed drive
// - Setup bit 10 disables amplitude correction
// - Setup bit 11 selects activation current
// - Setup bit 6 boosts channel 0
// - One level register per channel
// - Report amplitude outside 1.2-1.8 V
// - Below 0.6 V stop producing results
// - Channels 2 and 3 only four-channel
// - Maximum code makes activation select moot
// - Only active channel driven, others grounded
module sdc_drive_cfg
  import sdc_pkg::*;
#(
  parameter int NUM_CH = 4  // 2 or 4 channels
)(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // Register port
  input  wire logic              regWe,
  input  wire logic              regRe,
  input  wire logic [7:0]        regAddr,
  input  wire logic [15:0]       regWdata,
  output logic [15:0]            regRdata,
  output logic                   regAck,
  // Sequencer
  input  wire logic [1:0]        activeCh,
  input  wire logic [1:0]        phase,      // sdc_phase_t code
  input  wire logic              sleepMode,
  input  wire logic              multiChan,
  // Calibration engine
  input  wire logic              calWe,
  input  wire logic [1:0]        calCh,
  input  wire logic [4:0]        calCode,
  input  wire logic [4:0]        autoCode,   // Code chosen by correction loop
  // Amplitude comparators
  input  wire logic              ampBelowLow,
  input  wire logic              ampAboveHigh,
  input  wire logic              ampBelowStop,
  // Driver controls
  output logic [4:0]             driveCode,
  output logic [NUM_CH-1:0]      chDriveEn,  // Sensor pins driven
  output logic [NUM_CH-1:0]      chGround,   // Sensor pins grounded
  output logic                   ch0Boost,
  output logic                   ampCorrOn,
  output logic                   ampOutWindow,
  output logic                   convHalt
);
  initial begin
    if (NUM_CH != 2 && NUM_CH != 4) begin
      $error("NUM_CH must be 2 or 4");
    end
  end

  // Channel count in the width of the widened channel index
  localparam logic [2:0] NUM_CH_W = 3'(NUM_CH);

  logic [15:0] setup_q, setup_d;       // Setup register
  logic [15:0] rdata_q, rdata_d;       // Read data
  logic        ack_q, ack_d;           // Access acknowledge
  logic [4:0]  code_q, code_d;         // Code to driver
  logic [NUM_CH-1:0] en_q, en_d;       // Driven channels
  logic [4:0]  progC [NUM_CH];
  logic [4:0]  calC  [NUM_CH];
  logic [4:0]  appC  [NUM_CH];
  logic        activeOk;
  logic        settleStart;
  logic        driving;
  logic        fixedDrive;
  sdc_phase_t  phaseE;
  sdc_phase_t  phasePrev_q;

  // Phase code as the sequencer presents it; code 3 is treated as off
  assign phaseE   = sdc_phase_t'(phase);
  assign activeOk = {1'b0, activeCh} < NUM_CH_W;
  // drive only while settling or converting and awake
  assign driving  = !sleepMode && activeOk &&
                    (phaseE == SDC_PH_SETTLE || phaseE == SDC_PH_CONV);
  // Entry into settle: the one cycle in which a channel may take a new code
  assign settleStart = (phaseE == SDC_PH_SETTLE) && (phasePrev_q != SDC_PH_SETTLE);
  assign fixedDrive = setup_q[SDC_BIT_OVERRIDE] && setup_q[SDC_BIT_AMPOFF];

  // Per channel drive register
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gCh
      sdc_code_reg uCode (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .progWe      (regWe && regAddr == SDC_OFS_LVL0 + 8'(g)),
        .progIn      (regWdata[SDC_PROG_HI:SDC_PROG_LO]),
        .calWe       (calWe && calCh == 2'(g)),
        .calIn       (calCode),
        .settleStart (settleStart && activeCh == 2'(g)),
        .progCode    (progC[g]),
        .calCode     (calC[g]),
        .appliedCode (appC[g])
      );
    end
  endgenerate

  // Register access next state
  always_comb begin
    setup_d = setup_q;
    rdata_d = 16'h0000;
    ack_d   = regWe || regRe;
    if (regWe && regAddr == SDC_OFS_SETUP) begin
      setup_d = regWdata & SDC_SETUP_MASK;
    end
    if (regRe) begin
      if (regAddr == SDC_OFS_SETUP) begin
        rdata_d = setup_q;
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (regAddr == SDC_OFS_LVL0 + 8'(i)) begin
          rdata_d = {progC[i], calC[i], 6'h00};
        end
      end
    end
  end

  // Drive selection next state
  always_comb begin
    code_d = SDC_CODE_RST;
    en_d   = '0;
    if (driving) begin
      en_d[activeCh] = 1'b1;
      if (fixedDrive) begin
        code_d = appC[activeCh];
      end else begin
        code_d = autoCode;
      end
      if (phaseE == SDC_PH_SETTLE && !setup_q[SDC_BIT_ACTSEL]) begin
        code_d = SDC_CODE_MAX;
      end
    end
  end

  // Registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      setup_q     <= SDC_SETUP_RST;
      rdata_q     <= 16'h0000;
      ack_q       <= 1'b0;
      code_q      <= SDC_CODE_RST;
      en_q        <= '0;
      phasePrev_q <= SDC_PH_OFF;
    end else begin
      setup_q     <= setup_d;
      rdata_q     <= rdata_d;
      ack_q       <= ack_d;
      code_q      <= code_d;
      en_q        <= en_d;
      phasePrev_q <= phaseE;
    end
  end

  // Amplitude status
  sdc_amp_mon uMon (
    .mclk         (mclk),
    .rst_b        (rst_b),
    .ampBelowLow  (ampBelowLow),
    .ampAboveHigh (ampAboveHigh),
    .ampBelowStop (ampBelowStop),
    .active       (driving),
    .ampOutWindow (ampOutWindow),
    .oscStopped   (convHalt)
  );

  // Outputs from flip-flops so the driver never sees a glitch; ch0Boost also gates with the multiChan input
  assign regRdata  = rdata_q;
  assign regAck    = ack_q;
  assign driveCode = code_q;
  assign chDriveEn = en_q;
  assign chGround  = ~en_q;
  // boost on channel 0, gated off here while multiChan is high
  assign ch0Boost  = setup_q[SDC_BIT_BOOST] && !multiChan && en_q[0];
  assign ampCorrOn = !setup_q[SDC_BIT_AMPOFF];

  one_driven_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $onehot0(en_q))
    else $error("more than one channel driven");
  sleep_ground_a: assert property (@(posedge mclk) disable iff (!rst_b)
    sleepMode |=> en_q == '0)
    else $error("channel driven during sleep");
  conv_code_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (driving && fixedDrive && phaseE == SDC_PH_CONV) |=> driveCode == $past(appC[activeCh]))
    else $error("conversion not using programmed code");
  // without fixed drive use loop code
  auto_code_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (driving && !fixedDrive && phaseE == SDC_PH_CONV) |=> driveCode == $past(autoCode))
    else $error("auto code not used");
  setup_wr_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (regWe && regAddr == SDC_OFS_SETUP) |=> setup_q == ($past(regWdata) & SDC_SETUP_MASK))
    else $error("setup write lost");
  act_full_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (driving && phaseE == SDC_PH_SETTLE && !setup_q[SDC_BIT_ACTSEL]) |=> driveCode == 5'h1F)
    else $error("activation not full current");
  amp_corr_a: assert property (@(posedge mclk) disable iff (!rst_b)
    ampCorrOn == !setup_q[SDC_BIT_AMPOFF])
    else $error("correction enable wrong");
  // boost only on channel 0 single mode
  boost_ch0_a: assert property (@(posedge mclk) disable iff (!rst_b)
    ch0Boost |-> (!multiChan && chDriveEn[0]))
    else $error("boost outside channel 0 single mode");
  lvl_read_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (regRe && regAddr == SDC_OFS_LVL0) |=> regRdata[15:11] == $past(progC[0]))
    else $error("level read mismatch");

  // Register port answers

  ack_pulse_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (regWe || regRe) |=> regAck)
    else $error("access not acknowledged");
  ack_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !(regWe || regRe) |=> !regAck)
    else $error("acknowledge without access");
  rdata_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !regRe |=> regRdata == 16'h0000)
    else $error("read data outside read");
  unmapped_rd_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (regRe && regAddr == 8'h1B) |=> regRdata == 16'h0000)
    else $error("unmapped index returned data");
  cal_read_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (regRe && regAddr == SDC_OFS_LVL0) |=> regRdata[10:6] == $past(calC[0]))
    else $error("calibrated code read mismatch");
  setup_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !(regWe && regAddr == SDC_OFS_SETUP) |=> $stable(setup_q))
    else $error("setup changed without write");

  // Driver side

  ground_inv_a: assert property (@(posedge mclk) disable iff (!rst_b)
    chGround == ~chDriveEn)
    else $error("channel both driven and grounded");
  drive_active_a: assert property (@(posedge mclk) disable iff (!rst_b)
    driving |=> chDriveEn == (NUM_CH'(1) << $past(activeCh)))
    else $error("active channel not driven");
  idle_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !driving |=> (chDriveEn == '0 && driveCode == SDC_CODE_RST))
    else $error("drive while idle");
  boost_multi_a: assert property (@(posedge mclk) disable iff (!rst_b)
    multiChan |-> !ch0Boost)
    else $error("boost during sequencing");
  win_flag_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (driving && (ampBelowLow || ampAboveHigh)) |=> ampOutWindow)
    else $error("amplitude window not flagged");
  halt_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !driving |=> !convHalt)
    else $error("halt raised on idle channel");
endmodule

// ==== tb/sdc_host.sv ====
// Purpose: Host controller model that reaches the drive registers
// Assumes: One-cycle strobes, acknowledge one cycle after each strobe
// Notes:   Released address and data lines show inverted last values
`timescale 1ns/100ps
module sdc_host
  import sdc_pkg::*;
(
  // Clock
  input  wire logic        mclk,
  // Register port
  output logic             regWe,
  output logic             regRe,
  output logic [7:0]       regAddr,
  output logic [15:0]      regWdata,
  input  wire logic [15:0] regRdata,
  input  wire logic        regAck,
  // Operating mode known to the host
  input  wire logic        multiChan
);
  // Lowest parallel resistance of each code, in 100 ohm steps
  localparam int RpMin [9] = '{600, 518, 446, 384, 337, 295, 236, 205, 181};

  // Idle bus at time zero
  initial begin
    regWe    = 1'b0;
    regRe    = 1'b0;
    regAddr  = 8'h00;
    regWdata = 16'h0000;
  end

  function automatic logic [4:0] pickCode(input int rp);
    for (int i = 0; i < 9; i++) begin
      // First entry reached wins, so an overlap resolves to the higher resistance
      if (rp >= RpMin[i]) begin
        return 5'(i);
      end
    end
    return 5'h08;
  endfunction

  // One access: strobe for a cycle, then a bounded wait for acknowledge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] wd,
                      output logic [15:0] d);
    int n;
    if (w && multiChan && a == SDC_OFS_SETUP) begin
      wd[SDC_BIT_BOOST] = 1'b0;
    end
    @(posedge mclk) #1;
    regWe    = w;
    regRe    = !w;
    regAddr  = a;
    regWdata = wd;
    @(posedge mclk) #1;
    regWe    = 1'b0;
    regRe    = 1'b0;
    // Released lines must not look like the last value
    regAddr  = ~a;
    regWdata = ~wd;
    n = 0;
    while (regAck !== 1'b1 && n < 4) begin
      @(posedge mclk) #1;
      n++;
    end
    d = regRdata;
  endtask
endmodule

// ==== tb/sdc_drive_cfg_test.sv ====
// Purpose: Self-checking bench for the drive configuration block
// Assumes: Four-channel build; the host model owns the register port
// Notes:   Sequencer, calibrator and comparators are driven here
`timescale 1ns/100ps
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module sdc_drive_cfg_test
  import sdc_pkg::*;
;
  logic        mclk, rst_b, regWe, regRe, regAck, sleepMode, multiChan, calWe;
  logic        ampBelowLow, ampAboveHigh, ampBelowStop, ch0Boost, ampCorrOn;
  logic        ampOutWindow, convHalt;
  logic [7:0]  regAddr;
  logic [15:0] regWdata, regRdata, rd;
  logic [1:0]  activeCh, phase, calCh;
  logic [4:0]  calCode, autoCode, driveCode;
  logic [3:0]  chDriveEn, chGround;
  logic [4:0]  prog [4];  // Expected programmed codes
  logic [4:0]  cal [4];   // Expected calibrated codes
  logic [15:0] setups [4] = '{16'h1C00, 16'h1400, 16'h0400, 16'h1000};
  int          errors = 0, nTests = 0, cyc = 0, seed;

  sdc_drive_cfg #(.NUM_CH(4)) dut (.mclk(mclk), .rst_b(rst_b), .regWe(regWe),
    .regRe(regRe), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .regAck(regAck), .activeCh(activeCh), .phase(phase), .sleepMode(sleepMode),
    .multiChan(multiChan), .calWe(calWe), .calCh(calCh), .calCode(calCode),
    .autoCode(autoCode), .ampBelowLow(ampBelowLow), .ampAboveHigh(ampAboveHigh),
    .ampBelowStop(ampBelowStop), .driveCode(driveCode), .chDriveEn(chDriveEn),
    .chGround(chGround), .ch0Boost(ch0Boost), .ampCorrOn(ampCorrOn),
    .ampOutWindow(ampOutWindow), .convHalt(convHalt));
  sdc_host host (.mclk(mclk), .regWe(regWe), .regRe(regRe), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck), .multiChan(multiChan));

  // 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 8000) begin
      errors++;
      final_report();
    end
  end

  task automatic final_report;
    if (errors == 0 && nTests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Level register as read back: code, calibrated code, zero tail
  function automatic logic [15:0] expLevel(input logic [1:0] c);
    return {prog[c], cal[c], 6'h00};
  endfunction

  // Code reaching the driver for a setup, phase and channel
  function automatic logic [4:0] expDrive(input logic [15:0] s, input logic [1:0] p,
                                          input logic [1:0] c);
    // Full-current activation wins in settle whichever code source is chosen
    if (p == SDC_PH_SETTLE && !s[SDC_BIT_ACTSEL]) return SDC_CODE_MAX;
    if (!(s[SDC_BIT_OVERRIDE] && s[SDC_BIT_AMPOFF])) return autoCode;
    return prog[c];
  endfunction

  // Move the sequencer, then let latch and driver register settle
  task automatic setPh(input logic [1:0] c, input logic [1:0] p);
    @(posedge mclk) #1;
    activeCh = c;
    phase    = p;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  // One full dwell of a channel with checks in both drive phases
  task automatic runCh(input logic [1:0] c, input logic [15:0] s);
    setPh(c, SDC_PH_OFF);
    setPh(c, SDC_PH_SETTLE);
    `CHK("drive settle", expDrive(s, SDC_PH_SETTLE, c), driveCode)
    `CHK("drive enable", 4'h1 << c, chDriveEn)
    `CHK("grounded", ~(4'h1 << c), chGround)
    setPh(c, SDC_PH_CONV);
    `CHK("drive conv", expDrive(s, SDC_PH_CONV, c), driveCode)
  endtask

  initial begin
    rst_b = 1'b0;
    {activeCh, phase, calCh, sleepMode, multiChan, calWe} = '0;
    {calCode, autoCode, ampBelowLow, ampAboveHigh, ampBelowStop} = '0;
    seed = $urandom(32'h507f);
    repeat (5) @(posedge mclk);
    #1 rst_b = 1'b1;
    `CHK("ground reset", 4'hF, chGround)
    `CHK("corr reset", 1'b1, ampCorrOn)
    host.xfer(1'b0, SDC_OFS_SETUP, 16'h0000, rd);
    `CHK("setup reset", SDC_SETUP_RST, rd)
    // Only the four setup bits are kept
    host.xfer(1'b1, SDC_OFS_SETUP, 16'hFFFF, rd);
    host.xfer(1'b0, SDC_OFS_SETUP, 16'h0000, rd);
    `CHK("setup mask", SDC_SETUP_MASK, rd)
    `CHK("corr off", 1'b0, ampCorrOn)
    // Gap between setup and level registers is unmapped
    host.xfer(1'b1, 8'h1B, 16'hFFFF, rd);
    host.xfer(1'b0, 8'h1B, 16'h0000, rd);
    `CHK("unmapped", 16'h0000, rd)
    // Per-channel codes: zero and maximum as corners, the rest random
    for (int c = 0; c < 4; c++) begin
      host.xfer(1'b0, 8'(SDC_OFS_LVL0 + c), 16'h0000, rd);
      `CHK("level reset", 16'h0000, rd)
      prog[c] = (c == 0) ? 5'h00 : (c == 3) ? SDC_CODE_MAX : host.pickCode($urandom_range(181, 900));
      cal[c] = 5'($urandom);
      @(posedge mclk) #1;
      {calWe, calCh, calCode} = {1'b1, 2'(c), cal[c]};
      @(posedge mclk) #1;
      calWe = 1'b0;
      host.xfer(1'b1, 8'(SDC_OFS_LVL0 + c), {prog[c], 11'h7FF}, rd);
      host.xfer(1'b0, 8'(SDC_OFS_LVL0 + c), 16'h0000, rd);
      `CHK("level", expLevel(2'(c)), rd)
    end
    // Fixed drive with and without full-current activation, loop drive with it, on every channel
    autoCode = 5'($urandom);
    for (int k = 0; k < 4; k++) begin
      host.xfer(1'b1, SDC_OFS_SETUP, setups[k], rd);
      for (int c = 0; c < 4; c++) runCh(2'(c), setups[k]);
    end
    // A write in mid conversion waits for the next settle
    host.xfer(1'b1, SDC_OFS_SETUP, 16'h1C00, rd);
    runCh(2'd1, 16'h1C00);
    host.xfer(1'b1, SDC_OFS_LVL1, {~prog[1], 11'h000}, rd);
    setPh(2'd1, SDC_PH_CONV);
    `CHK("mid conv", prog[1], driveCode)
    prog[1] = ~prog[1];
    runCh(2'd1, 16'h1C00);
    // Amplitude comparators on the active channel
    for (int k = 0; k < 8; k++) begin
      {ampBelowStop, ampAboveHigh, ampBelowLow} = 3'(k);
      setPh(2'd1, SDC_PH_CONV);
      `CHK("window", |3'(k & 3), ampOutWindow)
      `CHK("halt", k[2], convHalt)
    end
    {ampBelowStop, ampAboveHigh, ampBelowLow} = 3'b000;
    // Boost only on channel 0 outside sequencing
    host.xfer(1'b1, SDC_OFS_SETUP, 16'h1C40, rd);
    runCh(2'd0, 16'h1C40);
    `CHK("boost", 1'b1, ch0Boost)
    multiChan = 1'b1;
    @(posedge mclk) #1;
    `CHK("boost multi", 1'b0, ch0Boost)
    host.xfer(1'b1, SDC_OFS_SETUP, 16'h1C40, rd);
    host.xfer(1'b0, SDC_OFS_SETUP, 16'h0000, rd);
    `CHK("host strip", 16'h1C00, rd)
    // Sleep grounds everything
    sleepMode = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    `CHK("sleep enable", 4'h0, chDriveEn)
    `CHK("sleep ground", 4'hF, chGround)
    final_report();
  end
endmodule
